// ### design/rsp_pkg.sv
// Constants for the relay serial slave port block.
// Assumes a 250 MHz mclk; software owns all protocol message contents.
package rsp_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD_SYNC = 64_000;
    localparam int BAUD_9600 = 9_600;
    localparam int BAUD_19200 = 19_200;
    localparam int BAUD_38400 = 38_400;
    localparam logic [14:0] DIV_SYNC = 15'(CLK_HZ / BAUD_SYNC);
    localparam logic [14:0] DIV_9600 = 15'(CLK_HZ / BAUD_9600);
    localparam logic [14:0] DIV_19200 = 15'(CLK_HZ / BAUD_19200);
    localparam logic [14:0] DIV_38400 = 15'(CLK_HZ / BAUD_38400);
    localparam logic [27:0] SEC_CYCLES = 28'(CLK_HZ);
    localparam logic [5:0] SEC_PER_MIN = 6'h3C;
    localparam logic [7:0] GAP_BITS = 8'h21;
    localparam logic [7:0] FRONT_ADDR = 8'h01;
    // Register byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_TIMER = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_REAR = 8'h10;
    localparam logic [7:0] OFS_FRONT = 8'h14;
    localparam logic [7:0] OFS_TSTAMP = 8'h18;
    localparam logic [7:0] OFS_ACCESS = 8'h1C;
    // Configuration fields
    localparam int CFG_PROTO = 0;
    localparam int CFG_PHYS = 2;
    localparam int CFG_PORT = 3;
    localparam int CFG_FRM10 = 4;
    localparam int CFG_BAUD = 5;
    localparam int CFG_PAR = 7;
    localparam int CFG_TSREV = 9;
    localparam int CFG_BLK = 10;
    localparam int CFG_W = 12;
    localparam logic [11:0] CFG_RST = 12'h020;
    localparam logic [7:0] ADDR_RST = 8'h01;
    localparam int TMR_INACT = 0;
    localparam int TMR_MEAS = 8;
    localparam logic [13:0] TMR_RST = 14'h1E0A;
    localparam logic [1:0] PROTO_VENDOR = 2'h0;
    localparam logic [1:0] PROTO_MODBUS = 2'h1;
    localparam logic [1:0] PROTO_IEC = 2'h2;
    localparam logic [1:0] RATE_9600 = 2'h0;
    localparam logic [1:0] RATE_38400 = 2'h2;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] BLK_MON = 2'h1;
    localparam logic [1:0] BLK_CMD = 2'h2;
    localparam logic [4:0] INACT_MAX = 5'h1E;
    localparam logic [5:0] MEAS_MAX = 6'h3C;
    // Status bits
    localparam int ST_RXERR = 0;
    localparam int ST_TXREF = 2;
    localparam int ST_REVERT = 4;
    localparam int ST_MEAS = 5;
    localparam int ST_RXVAL = 8;
    localparam int ST_TXBUSY = 10;
    localparam int ST_MONBLK = 12;
    localparam int ST_CMDBLK = 13;
    localparam int ST_FIBER = 14;
    localparam int ST_HIDDEN = 15;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b11,
        RX_STOP  = 2'b10
    } rsp_rx_type;
endpackage

// ### design/rsp_serial_ports.sv
// Front and first rear serial slave ports with APB register access.
// Assumes pins are asynchronous to mclk; firmware builds replies.
// Functional notes
// - Front port: 11-bit, 8 data, even, 1 stop
// - Front port fixed 19200 bps, address one
// - Front port: no auto extraction, no busy; the code keeps a front busy bit and refuses writes while it is set
// - Synchronous bus mode fixed at 64 kbit/s
// - Vendor protocol address 0..254, match only
// - Idle 1..30 minutes reverts, revokes password
// - Media copper default; fiber only when fitted
// - Copper offers sync bus or RS-485 choice
// - RS-485 frame 11-bit default, 10-bit option
// - Vendor RS-485 rates 9600, 19200, 38400
// - MODBUS address 1..247, unique per spur
// - MODBUS rates 9600, 19200, 38400, matched
// - MODBUS parity none, odd or even
// - MODBUS timestamp standard or reversed order
// - Master initiates; slave only answers
// - IEC103 address 0..254, unique per spur
// - IEC103 rates only 9600 and 19200
// - IEC103 cyclic measurements every 1..60 s
// - Monitor blocking refuses status, record reads
// - Command blocking refuses all remote commands
// - RS-485 half duplex: drive only replying
//
// The placing of the registers and the APB slave port were chosen for this implementation.
module rsp_serial_ports #(
    parameter logic [14:0] DIV_9600   = rsp_pkg::DIV_9600,
    parameter logic [14:0] DIV_19200  = rsp_pkg::DIV_19200,
    parameter logic [14:0] DIV_38400  = rsp_pkg::DIV_38400,
    parameter logic [27:0] SEC_CYCLES = rsp_pkg::SEC_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        frontRxd,
    output logic             frontTxd,
    input  wire logic        rearRxd,
    output logic             rearTxd,
    output logic             rearTxOe,
    input  wire logic        internalLogicSignal,
    input  wire logic        fiberFitted,
    input  wire logic        slotOccupied,
    output logic             passwordAccess,
    output logic             measDue,
    output logic             monitorBlocked,
    output logic             commandBlocked
);
    logic [4:0]  sync1_ff, sync2_ff;
    logic [11:0] cfg_ff;
    logic [7:0]  addr_ff;
    logic [13:0] tmr_ff;
    logic [31:0] tstamp_ff, prdata_ff;
    logic        pready_ff, pslverr_ff, pass_ff, revert_ff, meas_ff, monBlk_ff, cmdBlk_ff;
    logic [27:0] secCnt_ff;
    logic [5:0]  minSec_ff, measCnt_ff;
    logic [4:0]  inactCnt_ff;
    logic [1:0]  rxValid_ff, rxErr_ff, txRef_ff, permit_ff, txBusy_ff, txd_ff;
    logic [1:0]  addressed_ff, charDone, frameEnd, txGo, txTry, rdData;
    logic [7:0]  rxByte_ff [2];
    logic [14:0] bitDiv [2];
    logic [7:0]  stnAddr [2];
    logic [1:0]  parEn, parOdd, addrOk, rxIn, goodChar;

    // Two flops on each serial line and status input (not APB or reset) before any logic looks at it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_ff <= 5'h03;
            sync2_ff <= 5'h03;
        end else begin
            sync1_ff <= {slotOccupied, fiberFitted, internalLogicSignal, rearRxd, frontRxd};
            sync2_ff <= sync1_ff;
        end
    end
    assign rxIn = sync2_ff[1:0];
    wire ilsSync = sync2_ff[2];
    wire fitSync = sync2_ff[3];
    wire slotSync = sync2_ff[4];

    // Rear port configuration decode
    wire [1:0] proto = cfg_ff[rsp_pkg::CFG_PROTO +: 2];
    wire [1:0] rate = cfg_ff[rsp_pkg::CFG_BAUD +: 2];
    wire [1:0] parSel = cfg_ff[rsp_pkg::CFG_PAR +: 2];
    wire [1:0] blkSel = cfg_ff[rsp_pkg::CFG_BLK +: 2];
    wire isModbus = proto == rsp_pkg::PROTO_MODBUS;
    wire isIec = proto == rsp_pkg::PROTO_IEC;
    wire isVendor = !isModbus && !isIec;
    // Hidden selection reads as copper; the slot holds other hardware
    wire linkHidden = slotSync;
    wire physFiber = cfg_ff[rsp_pkg::CFG_PHYS] && fitSync && !linkHidden;
    wire syncBus = isVendor && !physFiber && !cfg_ff[rsp_pkg::CFG_PORT];
    wire is9600 = rate == rsp_pkg::RATE_9600;
    wire is38400 = rate == rsp_pkg::RATE_38400 && !isIec;
    wire [14:0] rearDiv = syncBus ? rsp_pkg::DIV_SYNC :
        is9600 ? DIV_9600 : is38400 ? DIV_38400 : DIV_19200;
    wire frame10 = isVendor && !syncBus && cfg_ff[rsp_pkg::CFG_FRM10];
    wire rearParEn = isModbus ? parSel != rsp_pkg::PAR_NONE : !frame10;
    wire rearParOdd = isModbus && parSel == rsp_pkg::PAR_ODD;
    wire rearAddrOk = isModbus ? (addr_ff != 8'h00 && addr_ff <= 8'hF7)
                               : addr_ff != 8'hFF;

    // Front port settings are wired constants, nothing to configure
    assign bitDiv[0] = DIV_19200;
    assign stnAddr[0] = rsp_pkg::FRONT_ADDR;
    assign parEn[0] = 1'b1;
    assign parOdd[0] = 1'b0;
    assign addrOk[0] = 1'b1;
    assign bitDiv[1] = rearDiv;
    assign stnAddr[1] = addr_ff;
    assign parEn[1] = rearParEn;
    assign parOdd[1] = rearParOdd;
    assign addrOk[1] = rearAddrOk;

    // APB decode
    wire setup = psel && penable && !pready_ff;
    wire access = psel && penable && pready_ff;
    wire wrEn = access && pwrite;
    wire rdEn = access && !pwrite;
    wire selCfg = paddr == rsp_pkg::OFS_CFG;
    wire selAddr = paddr == rsp_pkg::OFS_ADDR;
    wire selTmr = paddr == rsp_pkg::OFS_TIMER;
    wire selStat = paddr == rsp_pkg::OFS_STATUS;
    wire selRear = paddr == rsp_pkg::OFS_REAR;
    wire selFront = paddr == rsp_pkg::OFS_FRONT;
    wire selTs = paddr == rsp_pkg::OFS_TSTAMP;
    wire selAcc = paddr == rsp_pkg::OFS_ACCESS;
    wire mapped = selCfg | selAddr | selTmr | selStat | selRear | selFront | selTs | selAcc;
    wire [1:0] selData = {selRear, selFront};
    wire [1:0] w1cRxErr = (wrEn && selStat) ? pwdata[rsp_pkg::ST_RXERR +: 2] : 2'h0;
    wire [1:0] w1cTxRef = (wrEn && selStat) ? pwdata[rsp_pkg::ST_TXREF +: 2] : 2'h0;
    wire w1cRevert = wrEn && selStat && pwdata[rsp_pkg::ST_REVERT];
    wire w1cMeas = wrEn && selStat && pwdata[rsp_pkg::ST_MEAS];
    assign rdData = rdEn ? selData : 2'h0;
    assign txTry = wrEn ? selData : 2'h0;
    // Replies only inside a granted answer window
    assign txGo = txTry & permit_ff & ~txBusy_ff;

    // Timestamp byte order swap
    wire tsRev = isModbus && cfg_ff[rsp_pkg::CFG_TSREV];
    wire [31:0] tsView = tsRev ? {tstamp_ff[7:0], tstamp_ff[15:8], tstamp_ff[23:16],
                                  tstamp_ff[31:24]} : tstamp_ff;

    logic [31:0] stat;
    always_comb begin
        stat = 32'h0;
        stat[rsp_pkg::ST_RXERR +: 2] = rxErr_ff;
        stat[rsp_pkg::ST_TXREF +: 2] = txRef_ff;
        stat[rsp_pkg::ST_REVERT] = revert_ff;
        stat[rsp_pkg::ST_MEAS] = meas_ff;
        stat[rsp_pkg::ST_RXVAL +: 2] = rxValid_ff;
        stat[rsp_pkg::ST_TXBUSY +: 2] = txBusy_ff;
        stat[rsp_pkg::ST_MONBLK] = monBlk_ff;
        stat[rsp_pkg::ST_CMDBLK] = cmdBlk_ff;
        stat[rsp_pkg::ST_FIBER] = physFiber;
        stat[rsp_pkg::ST_HIDDEN] = linkHidden;
    end
    wire [31:0] rdMux = selCfg ? {20'h0, cfg_ff} : selAddr ? {24'h0, addr_ff} :
        selTmr ? {18'h0, tmr_ff} : selStat ? stat : selRear ? {24'h0, rxByte_ff[1]} :
        selFront ? {24'h0, rxByte_ff[0]} : selTs ? tsView : selAcc ? {31'h0, pass_ff} : 32'h0;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !mapped;
            prdata_ff <= (setup && !pwrite) ? rdMux : 32'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_ff <= rsp_pkg::CFG_RST;
            addr_ff <= rsp_pkg::ADDR_RST;
            tmr_ff <= rsp_pkg::TMR_RST;
            tstamp_ff <= 32'h0;
        end else if (wrEn) begin
            if (selCfg) cfg_ff <= pwdata[rsp_pkg::CFG_W-1:0];
            if (selAddr) addr_ff <= pwdata[7:0];
            if (selTmr) tmr_ff <= pwdata[13:0];
            if (selTs) tstamp_ff <= tsView == tstamp_ff && !tsRev ? pwdata : 
                {pwdata[7:0], pwdata[15:8], pwdata[23:16], pwdata[31:24]};
        end
    end

    // Second and minute timebase; setting limits clamp to legal range
    wire secTick = secCnt_ff == SEC_CYCLES - 28'h1;
    wire minTick = secTick && minSec_ff == rsp_pkg::SEC_PER_MIN - 6'h1;
    wire [4:0] inactRaw = tmr_ff[rsp_pkg::TMR_INACT +: 5];
    wire [5:0] measRaw = tmr_ff[rsp_pkg::TMR_MEAS +: 6];
    wire [4:0] inactLim = inactRaw == 5'h0 ? 5'h1 :
        inactRaw > rsp_pkg::INACT_MAX ? rsp_pkg::INACT_MAX : inactRaw;
    wire [5:0] measLim = measRaw == 6'h0 ? 6'h1 :
        measRaw > rsp_pkg::MEAS_MAX ? rsp_pkg::MEAS_MAX : measRaw;
    wire rearActive = frameEnd[1] && addressed_ff[1];
    // Full idle minutes only, so a partial first minute never shortens the wait
    wire revertNow = minTick && !rearActive && inactCnt_ff >= inactLim;
    wire measTick = isIec && secTick && measCnt_ff + 6'h1 >= measLim;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            secCnt_ff <= 28'h0;
            minSec_ff <= 6'h0;
            inactCnt_ff <= 5'h0;
            measCnt_ff <= 6'h0;
            pass_ff <= 1'b0;
            revert_ff <= 1'b0;
            meas_ff <= 1'b0;
            monBlk_ff <= 1'b0;
            cmdBlk_ff <= 1'b0;
        end else begin
            secCnt_ff <= secTick ? 28'h0 : secCnt_ff + 28'h1;
            minSec_ff <= minTick ? 6'h0 : secTick ? minSec_ff + 6'h1 : minSec_ff;
            inactCnt_ff <= (rearActive || revertNow) ? 5'h0 :
                minTick ? inactCnt_ff + 5'h1 : inactCnt_ff;
            measCnt_ff <= (measTick || !isIec) ? 6'h0 : secTick ? measCnt_ff + 6'h1 : measCnt_ff;
            // Revocation beats a same-cycle grant: fail safe
            pass_ff <= revertNow ? 1'b0 : (wrEn && selAcc) ? pwdata[0] : pass_ff;
            revert_ff <= revertNow || (revert_ff && !w1cRevert);
            meas_ff <= measTick || (meas_ff && !w1cMeas);
            monBlk_ff <= isIec && blkSel == rsp_pkg::BLK_MON && ilsSync;
            cmdBlk_ff <= isIec && blkSel == rsp_pkg::BLK_CMD && ilsSync;
        end
    end

    // One receive and transmit engine per port: 0 front, 1 rear
    for (genvar ch = 0; ch < 2; ch++) begin : g_port
        rsp_pkg::rsp_rx_type rxSt_ff;
        logic [14:0] rxDiv_ff, txDiv_ff;
        logic [3:0]  rxBit_ff, txBit_ff;
        logic [8:0]  rxSh_ff;
        logic [10:0] txSh_ff;
        logic [7:0]  gap_ff;
        logic        inFrame_ff, bad_ff;
        wire tickRx = rxDiv_ff == 15'h0;
        wire [3:0] nBits = parEn[ch] ? 4'h9 : 4'h8;
        wire [7:0] data = parEn[ch] ? rxSh_ff[7:0] : rxSh_ff[8:1];
        wire parErr = parEn[ch] && ((^rxSh_ff) != parOdd[ch]);
        assign charDone[ch] = rxSt_ff == rsp_pkg::RX_STOP && tickRx;
        assign goodChar[ch] = charDone[ch] && rxIn[ch] && !parErr;
        assign frameEnd[ch] = inFrame_ff && gap_ff == rsp_pkg::GAP_BITS;
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                rxSt_ff <= rsp_pkg::RX_IDLE;
                rxDiv_ff <= 15'h0;
                rxBit_ff <= 4'h0;
                rxSh_ff <= 9'h0;
            end else begin
                rxDiv_ff <= tickRx ? bitDiv[ch] - 15'h1 : rxDiv_ff - 15'h1;
                unique case (rxSt_ff)
                    rsp_pkg::RX_IDLE: if (!rxIn[ch]) begin
                        rxSt_ff <= rsp_pkg::RX_START;
                        rxDiv_ff <= bitDiv[ch] >> 1;
                    end
                    rsp_pkg::RX_START: if (tickRx) begin
                        rxSt_ff <= rxIn[ch] ? rsp_pkg::RX_IDLE : rsp_pkg::RX_BITS;
                        rxBit_ff <= 4'h0;
                    end
                    rsp_pkg::RX_BITS: if (tickRx) begin
                        rxSh_ff <= {rxIn[ch], rxSh_ff[8:1]};
                        rxBit_ff <= rxBit_ff + 4'h1;
                        if (rxBit_ff == nBits - 4'h1) rxSt_ff <= rsp_pkg::RX_STOP;
                    end
                    rsp_pkg::RX_STOP: if (tickRx) rxSt_ff <= rsp_pkg::RX_IDLE;
                endcase
            end
        end
        // Frame tracking: first char is the station address
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                gap_ff <= 8'h0;
                inFrame_ff <= 1'b0;
                bad_ff <= 1'b0;
                addressed_ff[ch] <= 1'b0;
                permit_ff[ch] <= 1'b0;
                rxValid_ff[ch] <= 1'b0;
                rxErr_ff[ch] <= 1'b0;
                rxByte_ff[ch] <= 8'h0;
            end else begin
                gap_ff <= rxSt_ff != rsp_pkg::RX_IDLE ? 8'h0 :
                    (tickRx && gap_ff != rsp_pkg::GAP_BITS) ? gap_ff + 8'h1 : gap_ff;
                if (charDone[ch] && !inFrame_ff) begin
                    inFrame_ff <= 1'b1;
                    bad_ff <= !goodChar[ch];
                    permit_ff[ch] <= 1'b0;
                    addressed_ff[ch] <= goodChar[ch] && addrOk[ch] &&
                        data == stnAddr[ch];
                end else if (charDone[ch]) begin
                    bad_ff <= bad_ff || !goodChar[ch];
                end else if (frameEnd[ch]) begin
                    inFrame_ff <= 1'b0;
                    // Only a clean frame for us opens a reply window
                    permit_ff[ch] <= addressed_ff[ch] && !bad_ff;
                    addressed_ff[ch] <= 1'b0;
                end
                if (goodChar[ch] && inFrame_ff && addressed_ff[ch]) rxByte_ff[ch] <= data;
                rxValid_ff[ch] <= (goodChar[ch] && inFrame_ff && addressed_ff[ch]) ||
                    (rxValid_ff[ch] && !rdData[ch]);
                rxErr_ff[ch] <= (charDone[ch] && !goodChar[ch]) ||
                    (rxErr_ff[ch] && !w1cRxErr[ch]);
            end
        end
        // Transmit; both sides signal busy while shifting, writes while busy or
        // outside a reply window are flagged as refused for firmware to retry
        wire txTick = txDiv_ff == 15'h0;
        wire txPar = (^pwdata[7:0]) ^ parOdd[ch];
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                txSh_ff <= 11'h7FF;
                txBit_ff <= 4'h0;
                txDiv_ff <= 15'h0;
                txBusy_ff[ch] <= 1'b0;
                txd_ff[ch] <= 1'b1;
                txRef_ff[ch] <= 1'b0;
            end else begin
                txRef_ff[ch] <= (txTry[ch] && !txGo[ch]) || (txRef_ff[ch] && !w1cTxRef[ch]);
                if (txGo[ch]) begin
                    txSh_ff <= {1'b1, parEn[ch] ? txPar : 1'b1, pwdata[7:0], 1'b0};
                    txBit_ff <= parEn[ch] ? 4'hB : 4'hA;
                    txDiv_ff <= 15'h0;
                    txBusy_ff[ch] <= 1'b1;
                end else if (txBusy_ff[ch] && txTick) begin
                    txd_ff[ch] <= txSh_ff[0];
                    txSh_ff <= {1'b1, txSh_ff[10:1]};
                    txDiv_ff <= bitDiv[ch] - 15'h1;
                    txBit_ff <= txBit_ff - 4'h1;
                    if (txBit_ff == 4'h0) txBusy_ff[ch] <= 1'b0;
                end else if (txBusy_ff[ch]) begin
                    txDiv_ff <= txDiv_ff - 15'h1;
                end
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign frontTxd = txd_ff[0];
    assign rearTxd = txd_ff[1];
    assign rearTxOe = txBusy_ff[1];
    assign passwordAccess = pass_ff;
    assign measDue = meas_ff;
    assign monitorBlocked = monBlk_ff;
    assign commandBlocked = cmdBlk_ff;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_front_frame_fix: assert property (parEn[0] && !parOdd[0])
        else $error("front frame not 8E1");
    a_front_rate_addr: assert property (bitDiv[0] == DIV_19200 && stnAddr[0] == 8'h01)
        else $error("front rate or address changed");
    a_sync_bus_rate: assert property (syncBus |-> bitDiv[1] == rsp_pkg::DIV_SYNC)
        else $error("sync bus not 64k");
    a_addr_match_ok: assert property ($rose(addressed_ff[1]) |-> $past(rearAddrOk))
        else $error("frame accepted with illegal address");
    a_revert_revoke: assert property (revertNow |=> !passwordAccess && revert_ff)
        else $error("password kept after idle");
    a_copper_default: assert property (!fitSync |-> !physFiber)
        else $error("fiber without interface");
    a_iec_rate_set: assert property (isIec |-> bitDiv[1] != DIV_38400)
        else $error("iec at 38400");
    a_reply_permit: assert property (txGo[1] |=> rearTxOe ##0 $past(permit_ff[1]))
        else $error("reply without request");
    a_monitor_block: assert property (monitorBlocked |-> $past(ilsSync) && $past(isIec))
        else $error("monitor block without cause");
    a_command_block: assert property (isIec && blkSel == rsp_pkg::BLK_CMD && ilsSync
        |=> commandBlocked)
        else $error("command block missed");
    a_half_duplex: assert property (!rearTxOe |-> rearTxd)
        else $error("line driven low while released");
    c_rear_frame: cover property (frameEnd[1] && addressed_ff[1] && !g_port[1].bad_ff);
    c_rear_reply: cover property (txGo[1]);
    c_revert: cover property (revertNow);
    c_meas_tick: cover property (measTick);
endmodule

// ### verif/rsp_master_model.sv
// Remote master station model driving the front and rear receive lines.
// Assumes idle-high lines (bus bias) and a caller that keeps frame gaps.
module rsp_master_model (
    input  wire logic mclk,
    output logic      frontLine,
    output logic      rearLine
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        frontLine = 1'b1;
        rearLine  = 1'b1;
    end
    // Only sent when the bench asks; rate and parity match the slave
    // No parity sends a second stop bit; bad flips parity
    task automatic sendChar(input bit fr, input logic [7:0] d, input int dv,
                            input logic [1:0] par, input bit bad);
        logic [10:0] f;
        f = {1'b1, (par == 2'h0) | (^d ^ (par == 2'h1) ^ bad), d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            if (fr)
                frontLine <= f[i];
            else
                rearLine <= f[i];
            repeat (dv) @(posedge mclk);
        end
    endtask
endmodule

// ### verif/relay_serial_slave_ports_tb.sv
// Self-checking bench for the serial slave ports, APB master and random cfg.
// Assumes short dividers 16/8/4 and 100-cycle seconds.
module relay_serial_slave_ports_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DV[3] = '{16, 8, 4};
    logic        mclk, rst_n, psel, penable, pwrite, er, f10, pready, pslverr;
    logic        internalLogicSignal, fiberFitted, slotOccupied, frontRxd, frontTxd;
    logic        rearRxd, rearTxd, rearTxOe, passwordAccess, measDue;
    logic        monitorBlocked, commandBlocked;
    logic [7:0]  paddr, ad, ch;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [1:0]  pro, rt, pa;
    int          n_fail, check_count, k;

    rsp_serial_ports #(.DIV_9600(15'h0010), .DIV_19200(15'h0008), .DIV_38400(15'h0004),
        .SEC_CYCLES(28'h0000064)) rsp_serial_ports_i (.mclk, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frontRxd, .frontTxd,
        .rearRxd, .rearTxd, .rearTxOe, .internalLogicSignal, .fiberFitted,
        .slotOccupied, .passwordAccess, .measDue, .monitorBlocked, .commandBlocked);
    rsp_master_model rsp_master_model_i (.mclk, .frontLine(frontRxd), .rearLine(rearRxd));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic complete_run();
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        int j;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk) penable <= 1'b1;
        j = 0;
        do begin @(posedge mclk); j++; end while (pready !== 1'b1 && j < 20);
        if (j >= 20) begin n_fail++; complete_run(); end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rx(input bit fr, input logic [7:0] a, input int dv, input bit bad);
        rsp_master_model_i.sendChar(fr, a, dv, pa, bad);
        ch = 8'(rnd());
        rsp_master_model_i.sendChar(fr, ch, dv, pa, 1'b0);
        repeat (34 * dv + 40) @(posedge mclk);
    endtask
    // Character as it should appear on the line, start bit in bit 0
    function automatic logic [10:0] frameOf(input logic [7:0] d);
        return {1'b1, (pa == 2'h0) | (^d ^ (pa == 2'h1)), d, 1'b0};
    endfunction
    task automatic tx(input bit fr, input logic refused, input int dv);
        int j;
        logic [7:0]  d;
        logic [10:0] sh;
        d = 8'(rnd());
        apb(1'b1, fr ? rsp_pkg::OFS_FRONT : rsp_pkg::OFS_REAR, 32'(d));
        if (!refused) begin
            repeat (2) @(posedge mclk);
            chk({rearTxOe, fr ? frontTxd : rearTxd}, {30'h0, !fr, 1'b0}, "tx start");
            for (int i = 0; i < 11; i++) begin
                sh[i] = fr ? frontTxd : rearTxd;
                repeat (dv) @(posedge mclk);
            end
            chk(sh, frameOf(d), "tx char");
        end
        j = 0;
        do begin apb(1'b0, rsp_pkg::OFS_STATUS, 0); j++; end while (rd[11:10] && j < 99);
        chk(rd[11:10], 32'h0, "tx busy");
        chk(rd[fr ? 2 : 3], refused, "tx permit");
        chk(rearTxOe, 32'h0, "driver idle");
        apb(1'b1, rsp_pkg::OFS_STATUS, 32'h0000001F);
    endtask

    initial begin
        seed = 32'h20E9DB23;
        {n_fail, check_count, psel, penable, pwrite, paddr, pwdata, pa} = '0;
        {internalLogicSignal, fiberFitted, slotOccupied, rst_n} = '0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, rsp_pkg::OFS_CFG, 0);
        chk(rd, 32'h00000020, "cfg reset");
        apb(1'b0, rsp_pkg::OFS_TIMER, 0);
        chk(rd, 32'h00001E0A, "timer reset");
        apb(1'b0, 8'h20, 0);
        chk(er, 32'h1, "unmapped");
        tx(1'b0, 1'b1, 16);
        repeat (6) begin
            pro = 2'(rnd() % 3);
            rt = (pro == rsp_pkg::PROTO_IEC) ? 2'(rnd() % 2) : 2'(rnd() % 3);
            f10 = (pro == rsp_pkg::PROTO_VENDOR) & rnd() >> 31;
            pa = (pro == rsp_pkg::PROTO_MODBUS) ? 2'(rnd() % 3) : (f10 ? 2'h0 : 2'h2);
            ad = (pro == rsp_pkg::PROTO_MODBUS) ? 8'(1 + rnd() % 247) : 8'(rnd() % 255);
            apb(1'b1, rsp_pkg::OFS_CFG, {23'h0, pa, rt, f10, 2'h2, pro});
            apb(1'b1, rsp_pkg::OFS_ADDR, 32'(ad));
            rx(1'b0, ad, DV[rt], 1'b0);
            apb(1'b0, rsp_pkg::OFS_REAR, 0);
            chk(rd, {24'h0, ch}, "rear data");
            tx(1'b0, 1'b0, DV[rt]);
            rx(1'b0, (ad == 8'h01) ? 8'h02 : ad - 8'h01, DV[rt], 1'b0);
            tx(1'b0, 1'b1, DV[rt]);
            if (pa != 2'h0) begin
                rx(1'b0, ad, DV[rt], 1'b1);
                tx(1'b0, 1'b1, DV[rt]);
            end
        end
        pa = 2'h2;
        rx(1'b1, rsp_pkg::FRONT_ADDR, 8, 1'b0);
        apb(1'b0, rsp_pkg::OFS_FRONT, 0);
        chk(rd, {24'h0, ch}, "front data");
        tx(1'b1, 1'b0, 8);
        rx(1'b1, 8'h02, 8, 1'b0);
        tx(1'b1, 1'b1, 8);
        apb(1'b1, rsp_pkg::OFS_CFG, 32'h00000001);
        apb(1'b1, rsp_pkg::OFS_TSTAMP, 32'h0123ABCD);
        apb(1'b1, rsp_pkg::OFS_CFG, 32'h00000201);
        apb(1'b0, rsp_pkg::OFS_TSTAMP, 0);
        chk(rd, 32'hCDAB2301, "stamp reversed");
        fiberFitted <= 1'b1;
        apb(1'b1, rsp_pkg::OFS_CFG, 32'h0000000E);
        apb(1'b0, rsp_pkg::OFS_STATUS, 0);
        chk(rd[15:14], 32'h1, "fiber on");
        slotOccupied <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b0, rsp_pkg::OFS_STATUS, 0);
        chk(rd[15:14], 32'h2, "media hidden");
        slotOccupied <= 1'b0;
        for (int b = 0; b < 3; b++) begin
            apb(1'b1, rsp_pkg::OFS_CFG, 32'(b << 10) | 32'h0000000A);
            internalLogicSignal <= 1'b1;
            repeat (6) @(posedge mclk);
            chk({commandBlocked, monitorBlocked}, b, "blocked");
            internalLogicSignal <= 1'b0;
            repeat (6) @(posedge mclk);
            chk({commandBlocked, monitorBlocked}, 32'h0, "unblocked");
        end
        apb(1'b1, rsp_pkg::OFS_TIMER, 32'h00000101);
        apb(1'b1, rsp_pkg::OFS_STATUS, 32'h00000020);
        k = 0;
        do begin @(posedge mclk); k++; end while (measDue !== 1'b1 && k < 110);
        chk(measDue, 32'h1, "meas due");
        rx(1'b0, ad, 16, 1'b0);
        apb(1'b1, rsp_pkg::OFS_ACCESS, 32'h00000001);
        repeat (2) @(posedge mclk);
        chk(passwordAccess, 32'h1, "password set");
        k = 0;
        do begin @(posedge mclk); k++; end while (passwordAccess === 1'b1 && k < 12100);
        chk(passwordAccess, 32'h0, "password revoked");
        chk(k > 5900, 32'h1, "revoked early");
        complete_run();
    end
endmodule
